//--- ufm_consts.svh
// constants of the uart format and modem control block
// assumes inclusion by bare name from the modules that use it
// Summary of operation
// - parity off, or odd, even, forced one, forced zero by two bits
// - stop bits one; or one and a half for 5 bits, else two
// - word length field 00..11 gives 5..8 bits for both directions
// - clock select 0 feeds input clock divided by sixteen to baud generator
// - clock select 1 divides the sixteenth clock by four more
// - infrared enable routes transmit and receive through infrared coding
// - infrared transmit output stays low while no data is sent
// - interrupt type 0 active or three-state, 1 open-source wire-or
// - loop-back cuts data and modem pins and loops them internally
// - receiver and transmitter interrupts keep working in loop-back
// - loop-back modem status comes from lower four control bits, still gated
// - reset clears clock select, infrared, interrupt type and loop-back
// - loop-back ring from aux output one, carrier from aux output two
`ifndef UFM_CONSTS_SVH
`define UFM_CONSTS_SVH

`define UFM_ADDR_W    3
`define UFM_OFS_LFC   3'h3
`define UFM_OFS_MC    3'h4
`define UFM_OFS_MS    3'h6

`define UFM_LFC_WLEN  0
`define UFM_LFC_STOP  2
`define UFM_LFC_PEN   3
`define UFM_LFC_EVEN  4
`define UFM_LFC_STICK 5

`define UFM_MC_DTR    0
`define UFM_MC_RTS    1
`define UFM_MC_AUX1   2
`define UFM_MC_AUX2   3
`define UFM_MC_LOOP   4
`define UFM_MC_ITYPE  5
`define UFM_MC_IREN   6
`define UFM_MC_CLKSEL 7

`define UFM_LFC_RST   8'h00
`define UFM_MC_RST    8'h00

`define UFM_PRE_LAST  4'hf
`define UFM_DIV4_LAST 2'h3
`define UFM_GAP_X1    7'h10
`define UFM_GAP_X4    7'h40

`endif

//--- ufm_ctrl.sv
// uart character format, prescale, infrared routing, interrupt driver
// and loop-back control, with a small register port
// assumes a 100 mhz core clock and pins asynchronous to it
`timescale 1ns/100ps
`include "ufm_consts.svh"
module ufm_ctrl
  import ufm_pkg::*;
(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_reset_n,
  input  wire logic [`UFM_ADDR_W-1:0] i_addr,
  input  wire logic [7:0]             i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [7:0]             o_rdata,
  input  wire logic                   i_tx_serial,
  input  wire logic [7:0]             i_tx_data,
  input  wire logic [7:0]             i_rx_data,
  input  wire logic                   i_rx_par,
  input  wire logic                   i_int_req,
  input  wire logic                   i_ier_msi,
  input  wire logic                   i_rx_pin,
  input  wire logic                   i_ir_rx_pin,
  input  wire logic                   i_cts_n,
  input  wire logic                   i_dsr_n,
  input  wire logic                   i_dcd_n,
  input  wire logic                   i_ri_n,
  output ufm_fmt_type                 o_fmt,
  output logic                        o_tx_par,
  output logic                        o_rx_par_err,
  output logic                        o_baud_tick,
  output logic                        o_tx_pin,
  output logic                        o_ir_tx,
  output logic                        o_rx_serial,
  output logic                        o_rts_n,
  output logic                        o_dtr_n,
  output ufm_modem_type               o_modem,
  output logic                        o_msi,
  output logic                        o_int_out,
  output logic                        o_int_oe
);

  logic          rst_s1_r;
  logic          rst_n_r;
  logic [7:0]    lfc_r;
  logic [7:0]    mc_r;
  logic [5:0]    pin_s1_r;
  logic [5:0]    pin_s2_r;
  logic [5:0]    pin_s3_r;
  logic [5:0]    pin_r;
  ufm_modem_type modem_nxt;
  logic          loop;
  logic          ir_on;

  // parity bit for the data masked to the word length
  function automatic logic ufm_parity(input logic [7:0] data,
                                      input ufm_fmt_type fmt);
    logic [7:0] mask;
    logic       ones;
    mask = 8'hff >> (4'h8 - fmt.data_bits);
    ones = ^(data & mask);
    unique case (fmt.par_mode)
      UFM_PAR_ODD:   ufm_parity = ~ones;
      UFM_PAR_EVEN:  ufm_parity = ones;
      UFM_PAR_MARK:  ufm_parity = 1'b1;
      UFM_PAR_SPACE: ufm_parity = 1'b0;
    endcase
  endfunction : ufm_parity

  // reset release through two flops
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // line format register
  always_ff @(posedge i_core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      lfc_r <= `UFM_LFC_RST;
    else if (i_wr && i_addr == `UFM_OFS_LFC)
      lfc_r <= i_wdata;
  end

  // modem control register
  always_ff @(posedge i_core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      mc_r <= `UFM_MC_RST;
    else if (i_wr && i_addr == `UFM_OFS_MC)
      mc_r <= i_wdata;
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge i_core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      o_rdata <= 8'h00;
    else if (!i_rd)
      o_rdata <= 8'h00;
    else
    begin
      unique case (i_addr)
        `UFM_OFS_LFC: o_rdata <= lfc_r;
        `UFM_OFS_MC:  o_rdata <= mc_r;
        `UFM_OFS_MS:  o_rdata <= {4'h0, o_modem};
        default:      o_rdata <= 8'h00;
      endcase
    end
  end

  // decoded character format
  always_ff @(posedge i_core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      o_fmt <= '{data_bits: 4'h5, par_en: 1'b0,
                 par_mode: UFM_PAR_ODD, stop_half: 3'h2};
    end
    else
    begin
      o_fmt.data_bits <= {2'h0, lfc_r[`UFM_LFC_WLEN+:2]} + 4'h5;
      o_fmt.par_en    <= lfc_r[`UFM_LFC_PEN];
      o_fmt.par_mode  <= ufm_par_type'({lfc_r[`UFM_LFC_STICK],
                                        lfc_r[`UFM_LFC_EVEN]});
      if (!lfc_r[`UFM_LFC_STOP])
        o_fmt.stop_half <= 3'h2;
      else if (lfc_r[`UFM_LFC_WLEN+:2] == 2'h0)
        o_fmt.stop_half <= 3'h3;
      else
        o_fmt.stop_half <= 3'h4;
    end
  end

  // parity for the transmitter and check for the receiver
  always_ff @(posedge i_core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      o_tx_par     <= 1'b0;
      o_rx_par_err <= 1'b0;
    end
    else
    begin
      o_tx_par     <= o_fmt.par_en & ufm_parity(i_tx_data, o_fmt);
      o_rx_par_err <= o_fmt.par_en &
                      (i_rx_par != ufm_parity(i_rx_data, o_fmt));
    end
  end

  ufm_prescale u_prescale
  (
    .i_core_clk (i_core_clk),
    .i_rst_n    (rst_n_r),
    .i_div4     (mc_r[`UFM_MC_CLKSEL]),
    .o_tick     (o_baud_tick)
  );

  // pin synchronisers: rx, ir rx, cts, dsr, dcd, ri
  always_ff @(posedge i_core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      pin_s1_r <= 6'h3d;
      pin_s2_r <= 6'h3d;
      pin_s3_r <= 6'h3d;
      pin_r    <= 6'h3d;
    end
    else
    begin
      pin_s1_r <= {i_ri_n, i_dcd_n, i_dsr_n, i_cts_n, i_ir_rx_pin, i_rx_pin};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_r    <= (pin_s2_r & pin_s3_r) | (pin_r & (pin_s2_r | pin_s3_r));
    end
  end

  assign loop  = mc_r[`UFM_MC_LOOP];
  assign ir_on = mc_r[`UFM_MC_IREN] & ~loop;

  // serial data routing
  always_ff @(posedge i_core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      o_tx_pin    <= 1'b1;
      o_ir_tx     <= 1'b0;
      o_rx_serial <= 1'b1;
    end
    else
    begin
      o_tx_pin <= loop | ir_on | i_tx_serial;
      o_ir_tx  <= ir_on & ~i_tx_serial;
      if (loop)
        o_rx_serial <= i_tx_serial;
      else if (ir_on)
        o_rx_serial <= ~pin_r[1];
      else
        o_rx_serial <= pin_r[0];
    end
  end

  // modem status source
  always_comb
  begin
    if (loop)
    begin
      modem_nxt.cts = mc_r[`UFM_MC_RTS];
      modem_nxt.dsr = mc_r[`UFM_MC_DTR];
      modem_nxt.ri  = mc_r[`UFM_MC_AUX1];
      modem_nxt.dcd = mc_r[`UFM_MC_AUX2];
    end
    else
    begin
      modem_nxt.cts = ~pin_r[2];
      modem_nxt.dsr = ~pin_r[3];
      modem_nxt.ri  = ~pin_r[5];
      modem_nxt.dcd = ~pin_r[4];
    end
  end

  // modem status, change interrupt and modem outputs
  always_ff @(posedge i_core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      o_modem <= 4'h0;
      o_msi   <= 1'b0;
      o_rts_n <= 1'b1;
      o_dtr_n <= 1'b1;
    end
    else
    begin
      o_modem <= modem_nxt;
      o_msi   <= i_ier_msi & (modem_nxt != o_modem);
      o_rts_n <= loop | ~mc_r[`UFM_MC_RTS];
      o_dtr_n <= loop | ~mc_r[`UFM_MC_DTR];
    end
  end

  // interrupt pin driver; loop-back leaves it untouched
  always_ff @(posedge i_core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      o_int_out <= 1'b0;
      o_int_oe  <= 1'b0;
    end
    else if (mc_r[`UFM_MC_ITYPE])
    begin
      o_int_out <= 1'b1;
      o_int_oe  <= i_int_req;
    end
    else
    begin
      o_int_out <= i_int_req;
      o_int_oe  <= mc_r[`UFM_MC_AUX2];
    end
  end

  // helper: cycles between baud ticks
  logic [6:0] gap_r;
  logic       seen_r;
  logic       sel_chg_r;
  logic       sel_prev_r;
  logic       sel_diff;

  // select changed since the last edge; spans the tick that opened the gap
  assign sel_diff = mc_r[`UFM_MC_CLKSEL] != sel_prev_r;

  always_ff @(posedge i_core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      gap_r      <= 7'h0;
      seen_r     <= 1'b0;
      sel_chg_r  <= 1'b0;
      sel_prev_r <= 1'b0;
    end
    else if (o_baud_tick)
    begin
      gap_r      <= 7'h1;
      seen_r     <= 1'b1;
      sel_chg_r  <= sel_diff;
      sel_prev_r <= mc_r[`UFM_MC_CLKSEL];
    end
    else
    begin
      gap_r      <= gap_r + 7'h1;
      sel_chg_r  <= sel_chg_r | sel_diff;
      sel_prev_r <= mc_r[`UFM_MC_CLKSEL];
    end
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!rst_n_r);

  parity_select_a: assert property (
    i_wr && i_addr == `UFM_OFS_LFC && !i_rd
    |=> ##1 o_fmt.par_en == $past(i_wdata[`UFM_LFC_PEN], 2) &&
      o_fmt.par_mode == ufm_par_type'($past(i_wdata[5:4], 2)))
    else $error("parity selection does not follow the write");

  stop_len_a: assert property (
    ##1 o_fmt.stop_half == (!$past(lfc_r[`UFM_LFC_STOP]) ? 3'h2 :
      ($past(lfc_r[1:0]) == 2'h0 ? 3'h3 : 3'h4)))
    else $error("stop length wrong");

  word_len_a: assert property (
    i_wr && i_addr == `UFM_OFS_LFC
    |=> ##1 o_fmt.data_bits == {2'h0, $past(i_wdata[1:0], 2)} + 4'h5)
    else $error("word length wrong");

  prescale_gap_a: assert property (
    o_baud_tick && seen_r && !sel_chg_r
    |-> gap_r == (sel_prev_r ? `UFM_GAP_X4 : `UFM_GAP_X1))
    else $error("baud tick spacing wrong");

  ir_idle_a: assert property (
    $past(ir_on) && $past(i_tx_serial) |-> !o_ir_tx && o_tx_pin)
    else $error("infrared output not low at idle");

  int_type_a: assert property (
    $past(mc_r[`UFM_MC_ITYPE]) |-> o_int_out && o_int_oe == $past(i_int_req))
    else $error("open-source interrupt drive wrong");

  loop_iso_a: assert property (
    loop [*2] |-> o_tx_pin && o_rts_n && o_dtr_n &&
      o_rx_serial == $past(i_tx_serial))
    else $error("loop-back not isolated");

  loop_modem_a: assert property (
    loop && $stable(mc_r) |=> o_modem == {$past(mc_r[3:2]),
      $past(mc_r[`UFM_MC_DTR]), $past(mc_r[`UFM_MC_RTS])})
    else $error("loop-back modem status wrong");

  msi_gate_a: assert property (
    !i_ier_msi |=> !o_msi)
    else $error("modem interrupt not gated");

  reset_clear_a: assert property (
    $rose(rst_n_r) |-> mc_r[7:4] == 4'h0)
    else $error("control bits not cleared by reset");

  loop_int_a: assert property (
    loop && !mc_r[`UFM_MC_ITYPE] |=> o_int_out == $past(i_int_req))
    else $error("interrupt lost in loop-back");

  loop_enter_c: cover property (!loop ##1 loop);
  ir_pulse_c: cover property (ir_on && o_ir_tx);
  div4_tick_c: cover property (o_baud_tick && mc_r[`UFM_MC_CLKSEL]);

endmodule : ufm_ctrl

//--- ufm_ctrl_tb.sv
// bench for the format, prescale, infrared, interrupt and loop-back control
// assumes the modem model on the pins and the register port as the master
`timescale 1ns/100ps
`include "ufm_consts.svh"
module ufm_ctrl_tb
  import ufm_pkg::*;
;
  logic          clk, rst_n, wr_s, rd_s, tx_serial, rx_par, int_req, ier_msi;
  logic [2:0]    addr;
  logic [7:0]    wdata, rdata, tx_data, rx_data, d;
  logic [5:0]    pdrv;
  logic          rx_pin, ir_rx_pin, cts_n, dsr_n, dcd_n, ri_n;
  logic          tx_par, par_err, tick, tx_pin, ir_tx, rx_serial, rts_n;
  logic          dtr_n, msi, int_out, int_oe;
  ufm_fmt_type   fmt;
  ufm_modem_type modem;
  int            err_total, checks_done, n;

  ufm_modem_model peer (.i_core_clk(clk), .i_drive(pdrv), .o_rx_pin(rx_pin),
    .o_ir_rx_pin(ir_rx_pin), .o_cts_n(cts_n), .o_dsr_n(dsr_n),
    .o_dcd_n(dcd_n), .o_ri_n(ri_n));
  ufm_ctrl dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
    .i_tx_serial(tx_serial), .i_tx_data(tx_data), .i_rx_data(rx_data),
    .i_rx_par(rx_par), .i_int_req(int_req), .i_ier_msi(ier_msi),
    .i_rx_pin(rx_pin), .i_ir_rx_pin(ir_rx_pin), .i_cts_n(cts_n),
    .i_dsr_n(dsr_n), .i_dcd_n(dcd_n), .i_ri_n(ri_n), .o_fmt(fmt),
    .o_tx_par(tx_par), .o_rx_par_err(par_err), .o_baud_tick(tick),
    .o_tx_pin(tx_pin), .o_ir_tx(ir_tx), .o_rx_serial(rx_serial),
    .o_rts_n(rts_n), .o_dtr_n(dtr_n), .o_modem(modem), .o_msi(msi),
    .o_int_out(int_out), .o_int_oe(int_oe));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    v = rdata;
  endtask : rd

  task automatic wt(output int c);
    c = 0;
    do
    begin
      cyc(1);
      c++;
      if (c > 200)
      begin
        chk(8'h00, 8'h01);
        results();
      end
    end while (tick !== 1'b1);
  endtask : wt

  task automatic t_reset;
    rd(3'h3, d);
    chk(d, 8'h00);
    rd(3'h4, d);
    chk(d, 8'h00);
    chk(fmt.data_bits, 8'h05);
    chk(fmt.stop_half, 8'h02);
    chk({tx_pin, ir_tx, int_oe}, 8'h04);
    wr(3'h7, 8'ha5);
    rd(3'h7, d);
    chk(d, 8'h00);
    wr(3'h6, 8'hff);
    rd(3'h6, d);
    chk(d, 8'h00);
    $display("reset test finished");
  endtask : t_reset

  task automatic t_format;
    for (int i = 0; i < 8; i++)
    begin
      wr(3'h3, 8'(i));
      cyc(3);
      chk(fmt.data_bits, 8'(5 + i % 4));
      chk(fmt.stop_half, i < 4 ? 8'h2 : (i == 4 ? 8'h3 : 8'h4));
    end
    rd(3'h3, d);
    chk(d, 8'h07);
    $display("format test finished");
  endtask : t_format

  task automatic t_parity;
    logic [7:0] lfc [5] = '{8'h03, 8'h0b, 8'h1b, 8'h2b, 8'h3b};
    logic       pe [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++)
    begin
      wr(3'h3, lfc[i]);
      tx_data <= 8'h07;
      rx_data <= 8'h07;
      rx_par <= ~pe[i];
      cyc(3);
      chk(fmt.par_en, 8'(i > 0));
      if (i > 0)
        chk(fmt.par_mode, 8'(i - 1));
      chk(tx_par, pe[i]);
      chk(par_err, 8'(i > 0));
    end
    $display("parity test finished");
  endtask : t_parity

  task automatic t_prescale;
    wt(n);
    wt(n);
    chk(8'(n), 8'h10);
    wr(3'h4, 8'h80);
    wt(n);
    wt(n);
    wt(n);
    chk(8'(n), 8'h40);
    $display("prescale test finished");
  endtask : t_prescale

  task automatic t_infrared;
    wr(3'h4, 8'h40);
    cyc(3);
    chk({ir_tx, tx_pin}, 8'h01);
    tx_serial <= 1'b0;
    pdrv <= 6'b111111;
    cyc(8);
    chk({ir_tx, rx_serial}, 8'h02);
    wr(3'h4, 8'h03);
    pdrv <= 6'b001111;
    cyc(8);
    chk({ir_tx, rx_serial, tx_pin, rts_n, dtr_n}, 8'h00);
    tx_serial <= 1'b1;
    pdrv <= 6'b101111;
    $display("infrared test finished");
  endtask : t_infrared

  task automatic t_int;
    wr(3'h4, 8'h08);
    int_req <= 1'b1;
    cyc(3);
    chk({int_oe, int_out}, 8'h03);
    int_req <= 1'b0;
    cyc(2);
    chk({int_oe, int_out}, 8'h02);
    wr(3'h4, 8'h20);
    cyc(3);
    chk({int_oe, int_out}, 8'h01);
    int_req <= 1'b1;
    cyc(2);
    chk({int_oe, int_out}, 8'h03);
    $display("interrupt type test finished");
  endtask : t_int

  task automatic t_loop;
    logic [7:0] mc [5] = '{8'h10, 8'h14, 8'h18, 8'h13, 8'h1f};
    logic [3:0] ex [5] = '{4'h0, 4'h4, 4'h8, 4'h3, 4'hf};
    ier_msi <= 1'b1;
    pdrv <= 6'b100000;
    cyc(8);
    chk(modem, 8'h0f);
    tx_serial <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      wr(3'h4, mc[i]);
      n = 0;
      repeat (4)
      begin
        cyc(1);
        n += (msi === 1'b1);
      end
      chk(modem, ex[i]);
      chk(8'(n > 0), 8'h01);
      chk({tx_pin, rx_serial, rts_n, dtr_n}, 8'h0b);
    end
    rd(3'h4, d);
    chk(d, 8'h1f);
    rd(3'h6, d);
    chk(d, 8'h0f);
    int_req <= 1'b0;
    cyc(2);
    chk({int_oe, int_out}, 8'h02);
    ier_msi <= 1'b0;
    wr(3'h4, 8'h10);
    n = 0;
    repeat (4)
    begin
      cyc(1);
      n += (msi === 1'b1);
    end
    chk(8'(n), 8'h00);
    $display("loop-back test finished");
  endtask : t_loop

  initial
  begin
    {rst_n, wr_s, rd_s, rx_par, int_req, ier_msi} = '0;
    {addr, wdata, tx_data, rx_data} = '0;
    tx_serial = 1'b1;
    pdrv = 6'b101111;
    err_total = 0;
    checks_done = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    cyc(3);
    t_reset();
    t_format();
    t_parity();
    t_prescale();
    t_infrared();
    t_int();
    t_loop();
    results();
  end
endmodule : ufm_ctrl_tb

//--- ufm_modem_model.sv
// modem or peripheral model: line, infrared and modem-status pins
// assumes the bench sets the wanted pin levels through i_drive
`timescale 1ns/100ps
module ufm_modem_model
(
  input  wire logic       i_core_clk,
  input  wire logic [5:0] i_drive,
  output logic            o_rx_pin,
  output logic            o_ir_rx_pin,
  output logic            o_cts_n,
  output logic            o_dsr_n,
  output logic            o_dcd_n,
  output logic            o_ri_n
);
  // pins move on the falling edge, away from the sampling edge
  always_ff @(negedge i_core_clk)
  begin
    {o_rx_pin, o_ir_rx_pin, o_cts_n, o_dsr_n, o_dcd_n, o_ri_n} <= i_drive;
  end
endmodule : ufm_modem_model

//--- ufm_pkg.sv
// types shared by the format and modem control block
// assumes the constants header is included by the modules
package ufm_pkg;

  typedef enum logic [1:0]
  {
    UFM_PAR_ODD   = 2'h0,
    UFM_PAR_EVEN  = 2'h1,
    UFM_PAR_MARK  = 2'h2,
    UFM_PAR_SPACE = 2'h3
  } ufm_par_type;

  typedef struct packed
  {
    logic [3:0]  data_bits;
    logic        par_en;
    ufm_par_type par_mode;
    logic [2:0]  stop_half;
  } ufm_fmt_type;

  typedef struct packed
  {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } ufm_modem_type;

endpackage : ufm_pkg

//--- ufm_prescale.sv
// baud prescaler: divide by sixteen, optionally by four more
// assumes a synchronised active-low reset on the core clock
`timescale 1ns/100ps
`include "ufm_consts.svh"
module ufm_prescale
  import ufm_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_div4,
  output logic      o_tick
);

  logic [3:0] pre_r;
  logic [1:0] div4_r;

  // divide by sixteen
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pre_r <= 4'h0;
    else
      pre_r <= pre_r + 4'h1;
  end

  // further divide by four
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      div4_r <= 2'h0;
    else if (pre_r == `UFM_PRE_LAST)
      div4_r <= div4_r + 2'h1;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_tick <= 1'b0;
    else if (i_div4)
      o_tick <= (pre_r == `UFM_PRE_LAST) &&
                (div4_r == `UFM_DIV4_LAST);
    else
      o_tick <= (pre_r == `UFM_PRE_LAST);
  end

endmodule : ufm_prescale
